/* ssm_defs.svh */
// Constants of the monitor status summary block: bit positions, reset
// values, event code limits. Assumes inclusion by bare name.
`ifndef SSM_DEFS_SVH
`define SSM_DEFS_SVH

// ****************************************
// Primary summary layout
// ****************************************
`define SSM_P_BLOWER_LO 0
`define SSM_P_BLOWER_HI 1
`define SSM_P_FILTER 2
`define SSM_P_TEMP_LO 3
`define SSM_P_TEMP_HI 16
`define SSM_P_VOLT_LO 17
`define SSM_P_VOLT_HI 25
`define SSM_P_BPL_LO 26
`define SSM_P_BPL_HI 29
`define SSM_P_OVF 30
`define SSM_P_MON_W 30
`define SSM_P_USED_MASK 32'h7FFFFFFF

// ****************************************
// Overflow summary layout
// ****************************************
`define SSM_O_MON_W 25
`define SSM_O_USED_MASK 32'h01FFFFE7

// ****************************************
// Event code list
// ****************************************
`define SSM_LIST_N 8
`define SSM_CODE_MIN 16'hF831
`define SSM_CODE_MAX 16'h03E8
`define SSM_PRESET_LO 16'hFE0D
`define SSM_PRESET_HI 16'h0000
`define SSM_ERR_RANGE 16'hFF22
`define SSM_REG_RESET 32'h00000000

`endif

/* ssm_pkg.sv */
// Types of the monitor status summary block.
// Assumes ssm_defs.svh is on the include path.
package ssm_pkg;

  typedef enum logic [3:0] {
    SSM_OP_NONE = 4'h0,
    SSM_OP_PRI_COND = 4'h1,
    SSM_OP_OVF_COND = 4'h2,
    SSM_OP_PRI_EVT = 4'h3,
    SSM_OP_OVF_EVT = 4'h4,
    SSM_OP_SUB_READ = 4'h5,
    SSM_OP_CLEAR_STATUS = 4'h6,
    SSM_OP_PRESET = 4'h7,
    SSM_OP_ENABLE_ALL = 4'h8,
    SSM_OP_LIST_BEGIN = 4'h9,
    SSM_OP_LIST_ENTRY = 4'hA,
    SSM_OP_LIST_COMMIT = 4'hB
  } ssm_op_type;

  typedef enum logic [2:0] {
    SSM_GRP_BLOWER = 3'h0,
    SSM_GRP_FILTER = 3'h1,
    SSM_GRP_TEMP = 3'h2,
    SSM_GRP_VOLT = 3'h3,
    SSM_GRP_BPL = 3'h4
  } ssm_grp_type;

  typedef struct packed {
    ssm_op_type op;
    ssm_grp_type grp;
    logic [15:0] lo;
    logic [15:0] hi;
  } ssm_cmd_type;

  typedef struct packed {
    logic valid;
    logic [15:0] code;
  } ssm_code_type;

endpackage

/* ssm_status_summary.sv */
// Monitor status summary: condition and latched event summaries plus the
// event code enable list that filters the error/event queue.
// Assumes a command decoder on clk_sys_i and asynchronous monitor pins.
// Notes on behaviour
// - Only codes inside the enable list of singles and ranges reach the queue.
// - Enable entries naming codes never reported are accepted without error.
// - Power-on and preset load the enable list with range -499 to 0.
// - An enable list holding an out-of-range value is rejected, error -222.
// - Enable-all sets the enable list to range -1999 through 1000.
// - Condition bits show current monitor failure; unused bits read zero.
// - Reading the primary condition register changes nothing.
// - Primary bit 30 is set while any overflow bit is set.
// - Primary event bits record blower, filter, temperature, voltage, backplane events.
// - Bits 0-1 blowers, 2 filter, 3-15 slot temperatures, 16 ambient.
// - Bits 17-25 nine supplies, 26-29 backplane signals, 31 unused.
// - Primary events read zero after power-on and clear-status.
// - Reading the primary event register clears nothing.
// - Reading a subsystem event register clears its group of primary event bits.
// - Overflow bits 0-2 and 5-8 supply currents, 9 total power.
// - Overflow bits 10-16 interrupt lines, 17-24 trigger lines, rest zero.
// - Overflow events zero after power-on and clear-status; reads clear nothing.
// - Overflow condition uses the overflow event layout for current state.
// - The queue is cleared at power-on and on clear-status.
`timescale 1ns/10ps
`default_nettype none
`include "ssm_defs.svh"

module ssm_status_summary (
  input wire logic clk_sys_i, // System clock, 100 MHz
  input wire logic arst_n_i, // Asynchronous reset, active low
  input wire logic ce_i, // Clock enable, freezes state when low
  input wire logic cmd_valid_i, // Command strobe
  input wire ssm_pkg::ssm_cmd_type cmd_i, // Command and arguments
  input wire logic [`SSM_P_MON_W-1:0] pri_mon_i, // Primary monitor fail pins
  input wire logic [`SSM_O_MON_W-1:0] ovf_mon_i, // Overflow monitor fail pins
  input wire ssm_pkg::ssm_code_type event_i, // Event code offered to queue
  output logic rsp_valid_o, // Query answer strobe
  output logic [31:0] rsp_data_o, // Query answer data
  output var ssm_pkg::ssm_code_type q_push_o, // Filtered event into queue
  output var ssm_pkg::ssm_code_type q_err_o, // Filtered own error into queue
  output logic queue_clear_o // Queue clear pulse
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rst_sync <= 2'h0;
    else if (ce_i)
      rst_sync <= {rst_sync[0], 1'b1};
  end

  assign rst_n = rst_sync[1];

  // ****************************************
  // Monitor pin synchronisers
  // ****************************************
  logic [`SSM_P_MON_W-1:0] pri_meta;
  logic [`SSM_P_MON_W-1:0] pri_sync;
  logic [`SSM_P_MON_W-1:0] pri_prev;
  logic [`SSM_O_MON_W-1:0] ovf_meta;
  logic [`SSM_O_MON_W-1:0] ovf_sync;
  logic [`SSM_O_MON_W-1:0] ovf_prev;

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pri_meta <= '0;
      pri_sync <= '0;
      pri_prev <= '0;
      ovf_meta <= '0;
      ovf_sync <= '0;
      ovf_prev <= '0;
    end
    else if (ce_i)
    begin
      pri_meta <= pri_mon_i;
      pri_sync <= pri_meta;
      pri_prev <= pri_sync;
      ovf_meta <= ovf_mon_i;
      ovf_sync <= ovf_meta;
      ovf_prev <= ovf_sync;
    end
  end

  // ****************************************
  // Condition views
  // ****************************************
  logic [31:0] ovf_cond;
  logic [31:0] pri_cond;

  // Unused overflow positions are masked off, not merely left low
  assign ovf_cond = {7'h00, ovf_sync} & `SSM_O_USED_MASK;
  assign pri_cond = {1'b0, |ovf_cond, pri_sync};

  // ****************************************
  // Command decode
  // ****************************************
  logic is_clear;
  logic is_sub_read;
  logic [31:0] sub_mask;

  assign is_clear = cmd_valid_i && (cmd_i.op == ssm_pkg::SSM_OP_CLEAR_STATUS);
  assign is_sub_read = cmd_valid_i && (cmd_i.op == ssm_pkg::SSM_OP_SUB_READ);

  always_comb
  begin
    sub_mask = 32'h00000000;
    unique case (cmd_i.grp)
      ssm_pkg::SSM_GRP_BLOWER: sub_mask[`SSM_P_BLOWER_HI:`SSM_P_BLOWER_LO] = '1;
      ssm_pkg::SSM_GRP_FILTER: sub_mask[`SSM_P_FILTER] = 1'b1;
      ssm_pkg::SSM_GRP_TEMP: sub_mask[`SSM_P_TEMP_HI:`SSM_P_TEMP_LO] = '1;
      ssm_pkg::SSM_GRP_VOLT: sub_mask[`SSM_P_VOLT_HI:`SSM_P_VOLT_LO] = '1;
      ssm_pkg::SSM_GRP_BPL: sub_mask[`SSM_P_BPL_HI:`SSM_P_BPL_LO] = '1;
      default: sub_mask = 32'h00000000;
    endcase
  end

  // ****************************************
  // Latched events
  // ****************************************
  logic [`SSM_P_MON_W-1:0] pri_evt;
  logic [`SSM_O_MON_W-1:0] ovf_evt;
  logic [`SSM_P_MON_W-1:0] pri_rise;
  logic [31:0] ovf_evt_view;
  logic [31:0] pri_evt_view;

  assign pri_rise = pri_sync & ~pri_prev;

  // Set beats clear so an edge arriving with the clearing read survives
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      pri_evt <= '0;
    else if (ce_i)
    begin
      if (is_clear)
        pri_evt <= pri_rise;
      else if (is_sub_read)
        pri_evt <= (pri_evt & ~sub_mask[`SSM_P_MON_W-1:0]) | pri_rise;
      else
        pri_evt <= pri_evt | pri_rise;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      ovf_evt <= '0;
    else if (ce_i)
    begin
      if (is_clear)
        ovf_evt <= ovf_sync & ~ovf_prev;
      else
        ovf_evt <= ovf_evt | (ovf_sync & ~ovf_prev);
    end
  end

  assign ovf_evt_view = {7'h00, ovf_evt} & `SSM_O_USED_MASK;
  assign pri_evt_view = {1'b0, |ovf_evt_view, pri_evt};

  // ****************************************
  // Query answers
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_valid_o <= 1'b0;
      rsp_data_o <= `SSM_REG_RESET;
    end
    else if (ce_i)
    begin
      rsp_valid_o <= 1'b0;
      if (cmd_valid_i)
      begin
        unique case (cmd_i.op)
          ssm_pkg::SSM_OP_PRI_COND:
          begin
            rsp_valid_o <= 1'b1;
            rsp_data_o <= pri_cond;
          end
          ssm_pkg::SSM_OP_OVF_COND:
          begin
            rsp_valid_o <= 1'b1;
            rsp_data_o <= ovf_cond;
          end
          ssm_pkg::SSM_OP_PRI_EVT:
          begin
            rsp_valid_o <= 1'b1;
            rsp_data_o <= pri_evt_view;
          end
          ssm_pkg::SSM_OP_OVF_EVT:
          begin
            rsp_valid_o <= 1'b1;
            rsp_data_o <= ovf_evt_view;
          end
          default:
            rsp_data_o <= rsp_data_o;
        endcase
      end
    end
  end

  // ****************************************
  // Enable list
  // ****************************************
  logic [15:0] list_lo [`SSM_LIST_N];
  logic [15:0] list_hi [`SSM_LIST_N];
  logic [`SSM_LIST_N-1:0] list_on;
  logic [15:0] stage_lo [`SSM_LIST_N];
  logic [15:0] stage_hi [`SSM_LIST_N];
  logic [`SSM_LIST_N-1:0] stage_on;
  logic stage_bad;
  logic [3:0] stage_cnt;
  logic entry_ok;
  logic is_entry;
  logic is_commit;
  logic reject;

  assign is_entry = cmd_valid_i && (cmd_i.op == ssm_pkg::SSM_OP_LIST_ENTRY);
  assign is_commit = cmd_valid_i && (cmd_i.op == ssm_pkg::SSM_OP_LIST_COMMIT);
  // Any code inside the reportable span is legal, reported or not
  assign entry_ok = ($signed(cmd_i.lo) >= $signed(`SSM_CODE_MIN))
    && ($signed(cmd_i.hi) <= $signed(`SSM_CODE_MAX))
    && ($signed(cmd_i.lo) <= $signed(cmd_i.hi))
    && (stage_cnt < 4'(`SSM_LIST_N));
  assign reject = is_commit && stage_bad;

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage_bad <= 1'b0;
      stage_cnt <= 4'h0;
      stage_on <= '0;
    end
    else if (ce_i)
    begin
      if (cmd_valid_i && (cmd_i.op == ssm_pkg::SSM_OP_LIST_BEGIN))
      begin
        stage_bad <= 1'b0;
        stage_cnt <= 4'h0;
        stage_on <= '0;
      end
      else if (is_entry)
      begin
        if (entry_ok)
        begin
          stage_on[stage_cnt[2:0]] <= 1'b1;
          stage_cnt <= stage_cnt + 4'h1;
        end
        else
          stage_bad <= 1'b1;
      end
    end
  end

  generate
    for (genvar g = 0; g < `SSM_LIST_N; g++)
    begin : g_list
      always_ff @(posedge clk_sys_i or negedge rst_n)
      begin
        if (!rst_n)
        begin
          stage_lo[g] <= 16'h0000;
          stage_hi[g] <= 16'h0000;
        end
        else if (ce_i && is_entry && entry_ok && (stage_cnt[2:0] == 3'(g)))
        begin
          stage_lo[g] <= cmd_i.lo;
          stage_hi[g] <= cmd_i.hi;
        end
      end

      always_ff @(posedge clk_sys_i or negedge rst_n)
      begin
        if (!rst_n)
        begin
          list_lo[g] <= (g == 0) ? `SSM_PRESET_LO : 16'h0000;
          list_hi[g] <= (g == 0) ? `SSM_PRESET_HI : 16'h0000;
          list_on[g] <= (g == 0);
        end
        else if (ce_i && cmd_valid_i)
        begin
          if (cmd_i.op == ssm_pkg::SSM_OP_PRESET)
          begin
            list_lo[g] <= (g == 0) ? `SSM_PRESET_LO : 16'h0000;
            list_hi[g] <= (g == 0) ? `SSM_PRESET_HI : 16'h0000;
            list_on[g] <= (g == 0);
          end
          else if (cmd_i.op == ssm_pkg::SSM_OP_ENABLE_ALL)
          begin
            list_lo[g] <= (g == 0) ? `SSM_CODE_MIN : 16'h0000;
            list_hi[g] <= (g == 0) ? `SSM_CODE_MAX : 16'h0000;
            list_on[g] <= (g == 0);
          end
          else if (is_commit && !stage_bad)
          begin
            list_lo[g] <= stage_lo[g];
            list_hi[g] <= stage_hi[g];
            list_on[g] <= stage_on[g];
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Queue filter
  // ****************************************
  function automatic logic in_list(input logic [15:0] code,
                                   input logic [`SSM_LIST_N-1:0] on,
                                   input logic [15:0] lo [`SSM_LIST_N],
                                   input logic [15:0] hi [`SSM_LIST_N]);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < `SSM_LIST_N; i++)
      hit = hit | (on[i] && ($signed(code) >= $signed(lo[i]))
        && ($signed(code) <= $signed(hi[i])));
    return hit;
  endfunction

  // Own error takes a lane of its own so no offered event is dropped for it
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q_push_o <= '0;
      q_err_o <= '0;
    end
    else if (ce_i)
    begin
      q_push_o.valid <= event_i.valid && !is_clear
        && in_list(event_i.code, list_on, list_lo, list_hi);
      q_push_o.code <= event_i.code;
      q_err_o.valid <= reject
        && in_list(`SSM_ERR_RANGE, list_on, list_lo, list_hi);
      q_err_o.code <= `SSM_ERR_RANGE;
    end
  end

  // Comes up high so the queue is emptied after power-on
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      queue_clear_o <= 1'b1;
    else if (ce_i)
      queue_clear_o <= is_clear;
  end

endmodule
`default_nettype wire

/* ssm_status_summary_monitor.sv */
// Port checker for the monitor status summary block.
// Assumes one clock domain and binding onto ssm_status_summary.
`timescale 1ns/10ps
`default_nettype none
`include "ssm_defs.svh"
module ssm_status_summary_monitor (
  input wire logic clk_sys_i, // Clock
  input wire logic arst_n_i, // Reset, active low
  input wire logic ce_i, // Clock enable
  input wire logic cmd_valid_i, // Command strobe
  input wire ssm_pkg::ssm_cmd_type cmd_i, // Command
  input wire logic [`SSM_P_MON_W-1:0] pri_mon_i, // Primary monitors
  input wire logic [`SSM_O_MON_W-1:0] ovf_mon_i, // Overflow monitors
  input wire ssm_pkg::ssm_code_type event_i, // Offered event
  input wire logic rsp_valid_o, // Answer strobe
  input wire logic [31:0] rsp_data_o, // Answer data
  input wire ssm_pkg::ssm_code_type q_push_o, // Queue push
  input wire ssm_pkg::ssm_code_type q_err_o, // Own error push
  input wire logic queue_clear_o // Queue clear
);
  // ****
  // Helpers
  // ****
  logic [1:0] live_sync;
  logic [2:0] stab;
  logic [29:0] pri_q;
  logic [24:0] ovf_q;
  logic live;
  logic run;
  logic take;
  logic is_q;
  logic take_pc;
  logic take_oc;
  logic take_ov;
  logic take_clr;
  logic offer;
  logic push_in;
  logic [15:0] ev_q;
  logic [31:0] ovf_used;
  logic [31:0] ovf_spare;
  logic [31:0] pri_exp;
  assign live = live_sync[1];
  assign run = ce_i && live;
  assign take = run && cmd_valid_i;
  assign is_q = cmd_i.op inside {[4'h1:4'h4]};
  // Pins stood still long enough that the synchronisers agree with them
  assign take_pc = take && (cmd_i.op == 4'h1) && (stab == 3'h7);
  assign take_oc = take && (cmd_i.op == 4'h2) && (stab == 3'h7);
  assign take_ov = take && (cmd_i.op inside {4'h2, 4'h4});
  assign take_clr = take && (cmd_i.op == 4'h6);
  assign offer = event_i.valid && ce_i;
  assign push_in = ($signed(q_push_o.code) >= $signed(`SSM_CODE_MIN))
    && ($signed(q_push_o.code) <= $signed(`SSM_CODE_MAX));
  assign ovf_used = {7'h00, ovf_q} & `SSM_O_USED_MASK;
  assign ovf_spare = rsp_data_o & ~`SSM_O_USED_MASK;
  assign pri_exp = {1'b0, |ovf_used, pri_q};
  // Mirrors the two-flop release so commands ignored inside it are not judged
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
    if (!arst_n_i)
      live_sync <= 2'h0;
    else if (ce_i)
      live_sync <= {live_sync[0], 1'b1};
  // Condition answers are judged only once the pins have settled past the synchronisers
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
    if (!arst_n_i)
      stab <= 3'h0;
    else if (pri_q != pri_mon_i || ovf_q != ovf_mon_i)
      stab <= 3'h0;
    else if (stab != 3'h7)
      stab <= stab + 3'h1;
  always_ff @(posedge clk_sys_i)
  begin
    pri_q <= pri_mon_i;
    ovf_q <= ovf_mon_i;
    ev_q <= event_i.code;
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  a_query_answer: assert property (take && is_q |=> rsp_valid_o)
    else $error("query not answered");
  a_answer_cause: assert property ($rose(rsp_valid_o) |-> $past(take && is_q))
    else $error("answer without query");
  a_ovf_unused: assert property (rsp_valid_o && $past(take_ov) |-> ovf_spare == 32'h0)
    else $error("unused overflow bit set");
  a_pri_cond: assert property ($past(take_pc) |-> rsp_data_o == $past(pri_exp))
    else $error("primary condition wrong");
  a_ovf_cond: assert property ($past(take_oc) |-> rsp_data_o == $past(ovf_used))
    else $error("overflow condition wrong");
  a_clear_pulse: assert property (take_clr |=> queue_clear_o)
    else $error("clear not passed on");
  a_clear_cause: assert property (queue_clear_o && $past(run) |-> $past(take_clr))
    else $error("stray queue clear");
  a_push_match: assert property (q_push_o.valid |-> $past(offer) && q_push_o.code == ev_q)
    else $error("push without matching event");
  a_push_span: assert property (q_push_o.valid |-> push_in)
    else $error("pushed code outside span");
  a_err_code: assert property (q_err_o.valid |-> q_err_o.code == `SSM_ERR_RANGE)
    else $error("wrong own error code");
  c_query: cover property (take && is_q ##1 rsp_valid_o);
  c_push: cover property (q_push_o.valid);
  c_err: cover property (q_err_o.valid);
  c_clear: cover property (take_clr ##1 queue_clear_o);
endmodule
bind ssm_status_summary ssm_status_summary_monitor u_mon (.clk_sys_i(clk_sys_i),
  .arst_n_i(arst_n_i), .ce_i(ce_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
  .pri_mon_i(pri_mon_i), .ovf_mon_i(ovf_mon_i), .event_i(event_i),
  .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .q_push_o(q_push_o),
  .q_err_o(q_err_o), .queue_clear_o(queue_clear_o));
`default_nettype wire

/* ssm_ctrl_model.sv */
// Remote controller model: issues commands and collects query answers.
// Assumes the block answers a query on the edge after it is taken.
`timescale 1ns/10ps
`default_nettype none
module ssm_ctrl_model (
  input wire logic clk_i, // System clock
  input wire logic rsp_valid_i, // Answer strobe
  input wire logic [31:0] rsp_data_i, // Answer data
  output var ssm_pkg::ssm_cmd_type cmd_o, // Command
  output logic cmd_valid_o // Command strobe
);
  initial
  begin
    cmd_o = '0;
    cmd_valid_o = 1'b0;
  end
  // One idle cycle after each strobe; released lines are inverted so stale data is not trusted
  task automatic send(input logic [3:0] op, input logic [2:0] grp, input logic [15:0] lo,
    input logic [15:0] hi);
    @(negedge clk_i);
    cmd_o = '{ssm_pkg::ssm_op_type'(op), ssm_pkg::ssm_grp_type'(grp), lo, hi};
    cmd_valid_o = 1'b1;
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    cmd_o = ssm_pkg::ssm_cmd_type'(~cmd_o);
  endtask
  task automatic query(input logic [3:0] op, output logic [32:0] ans);
    send(op, 3'h0, 16'h0000, 16'h0000);
    ans = {rsp_valid_i, rsp_data_i};
  endtask
endmodule
`default_nettype wire

/* ssm_status_summary_bench.sv */
// Self-checking bench for the monitor status summary block.
// Assumes ssm_ctrl_model as command source; inputs change on falling edges.
`timescale 1ns/10ps
`default_nettype none
module ssm_status_summary_bench;
  logic clk_sys_i = 1'b0;
  logic arst_n_i;
  logic ce_i;
  logic cmd_valid_i;
  ssm_pkg::ssm_cmd_type cmd_i;
  logic [29:0] pri_mon_i;
  logic [24:0] ovf_mon_i;
  ssm_pkg::ssm_code_type event_i;
  logic rsp_valid_o;
  logic [31:0] rsp_data_o;
  ssm_pkg::ssm_code_type q_push_o;
  ssm_pkg::ssm_code_type q_err_o;
  logic queue_clear_o;
  int bad_count = 0;
  int samples_checked = 0;
  int err_seen = 0;
  int g;
  logic [32:0] ans;
  logic [31:0] pev;
  logic [31:0] gmask [5] = '{32'h00000003, 32'h00000004, 32'h0001FFF8, 32'h03FE0000,
    32'h3C000000};
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
    if (q_err_o.valid === 1'b1)
    begin
      err_seen++;
      check({17'h0, q_err_o.code}, {17'h0, 16'hFF22});
    end
  ssm_status_summary dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .pri_mon_i(pri_mon_i), .ovf_mon_i(ovf_mon_i),
    .event_i(event_i), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .q_push_o(q_push_o), .q_err_o(q_err_o), .queue_clear_o(queue_clear_o));
  ssm_ctrl_model ctrl (.clk_i(clk_sys_i), .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o),
    .cmd_o(cmd_i), .cmd_valid_o(cmd_valid_i));
  // ****
  // Tasks
  // ****
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [3:0] op, input logic [31:0] exp);
    ctrl.query(op, ans);
    check(ans, {1'b1, exp});
  endtask
  task automatic ev(input logic [15:0] code, input logic pass);
    @(negedge clk_sys_i);
    event_i = '{1'b1, code};
    @(negedge clk_sys_i);
    check({16'h0, q_push_o.valid, pass ? q_push_o.code : 16'h0},
      {16'h0, pass, pass ? code : 16'h0});
    event_i = '{1'b0, ~code};
  endtask
  task automatic lst(input logic [15:0] lo, input logic [15:0] hi);
    ctrl.send(4'h9, 3'h0, 16'h0000, 16'h0000);
    ctrl.send(4'hA, 3'h0, lo, hi);
    ctrl.send(4'hB, 3'h0, 16'h0000, 16'h0000);
    repeat (3) @(negedge clk_sys_i);
  endtask
  task automatic final_report;
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ****
  // Sequence
  // ****
  initial
  begin
    arst_n_i = 1'b0;
    ce_i = 1'b1;
    pri_mon_i = '0;
    ovf_mon_i = '0;
    event_i = '0;
    repeat (3) @(negedge clk_sys_i);
    check({32'h0, queue_clear_o}, 33'h1);
    arst_n_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    check({32'h0, queue_clear_o}, 33'h0);
    rd(4'h3, 32'h0);
    rd(4'h4, 32'h0);
    ev(16'hFE0D, 1'b1);
    ev(16'hFE0C, 1'b0);
    ev(16'h0000, 1'b1);
    ev(16'h0001, 1'b0);
    pri_mon_i = 30'h2A020005;
    repeat (10) @(negedge clk_sys_i);
    rd(4'h1, 32'h2A020005);
    rd(4'h1, 32'h2A020005);
    rd(4'h3, 32'h2A020005);
    pri_mon_i = 30'h3FFFFFFF;
    ovf_mon_i = 25'h1FFFFFF;
    repeat (10) @(negedge clk_sys_i);
    rd(4'h1, 32'h7FFFFFFF);
    rd(4'h2, 32'h01FFFFE7);
    pri_mon_i = '0;
    ovf_mon_i = '0;
    repeat (10) @(negedge clk_sys_i);
    rd(4'h1, 32'h0);
    rd(4'h3, 32'h7FFFFFFF);
    rd(4'h3, 32'h7FFFFFFF);
    rd(4'h4, 32'h01FFFFE7);
    pev = 32'h7FFFFFFF;
    for (g = 0; g < 5; g++)
    begin
      ctrl.send(4'h5, g[2:0], 16'h0000, 16'h0000);
      pev = pev & ~gmask[g];
      rd(4'h3, pev);
    end
    rd(4'h4, 32'h01FFFFE7);
    // Frozen block takes no query and keeps its last answer
    @(negedge clk_sys_i);
    ce_i = 1'b0;
    ctrl.query(4'h3, ans);
    check(ans, {1'b0, 32'h01FFFFE7});
    ce_i = 1'b1;
    rd(4'h3, pev);
    ctrl.send(4'h6, 3'h0, 16'h0000, 16'h0000);
    check({32'h0, queue_clear_o}, 33'h1);
    rd(4'h3, 32'h0);
    rd(4'h4, 32'h0);
    ctrl.send(4'h8, 3'h0, 16'h0000, 16'h0000);
    ev(16'hF831, 1'b1);
    ev(16'hF830, 1'b0);
    ev(16'h03E8, 1'b1);
    ev(16'h03E9, 1'b0);
    ctrl.send(4'h9, 3'h0, 16'h0000, 16'h0000);
    ctrl.send(4'hA, 3'h0, 16'h0005, 16'h0005);
    ctrl.send(4'hA, 3'h0, 16'hFFF6, 16'hFFFD);
    ctrl.send(4'hA, 3'h0, 16'h0384, 16'h0384);
    ctrl.send(4'hB, 3'h0, 16'h0000, 16'h0000);
    repeat (3) @(negedge clk_sys_i);
    check(33'(err_seen), 33'h0);
    ev(16'h0005, 1'b1);
    ev(16'h0006, 1'b0);
    ev(16'hFFFD, 1'b1);
    ev(16'hFFF5, 1'b0);
    lst(16'hFF22, 16'hFF22);
    lst(16'h0000, 16'h03E9);
    check(33'(err_seen), 33'h1);
    ev(16'hFF22, 1'b1);
    ev(16'h0005, 1'b0);
    ctrl.send(4'h7, 3'h0, 16'h0000, 16'h0000);
    ev(16'hFE0D, 1'b1);
    ev(16'hFE0C, 1'b0);
    final_report;
  end
  // Whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    bad_count++;
    final_report;
  end
endmodule
`default_nettype wire
